//--- shared/adc_port_defs.svh
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH


// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define RESULT_W      14
`define RESULT_MSB    13
`define CHAN_NUM      8
`define CHAN_W        3
`define SER_CHAN_NUM  4
`define BUS_W         16
`define BIT_IDX_W     4

// ----------------------------------------------------------------
// bus line positions
// ----------------------------------------------------------------
`define LINE_SER_A    7
`define LINE_SER_B    8
`define LINE_HBF      14
`define LINE_BYTE_SEL 15

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_BUS       16'h0000
`define RST_OE_N      16'hffff
`define RST_PINS      6'h30
`define RST_RESULT    14'h0000

`endif

//--- shared/adc_port_pkg.sv
package adc_port_pkg;

  `include "adc_port_defs.svh"

  typedef enum logic [1:0] {
    MODE_WORD   = 2'b00,
    MODE_BYTE   = 2'b01,
    MODE_SERIAL = 2'b10
  } port_mode_e;

  typedef logic [`RESULT_W-1:0] result_t;

endpackage

//--- hw/pin_filter.sv
`timescale 1ns/100ps

module pin_filter #(
  parameter int          WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // raw and filtered pins
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // stage1 feeds stage2 only; a bit moves once stage2 and stage3 agree
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      stage1  <= RST_VAL;
      stage2  <= RST_VAL;
      stage3  <= RST_VAL;
      level_o <= RST_VAL;
    end else begin
      stage1  <= pin_i;
      stage2  <= stage1;
      stage3  <= stage2;
      level_o <= (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & level_o);
    end
  end

endmodule

//--- hw/result_port.sv
`timescale 1ns/100ps
`include "adc_port_defs.svh"

module result_port (
  // clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_n_i,
  // host strobes and straps
  input  wire logic                    cs_n_i,
  input  wire logic                    rd_sclk_i,
  input  wire logic                    interface_select_i,
  input  wire logic                    ref_select_i,
  // result bus, two-way
  input  wire logic [`BUS_W-1:0]       result_bus_i,
  output logic      [`BUS_W-1:0]       result_bus_o,
  output logic      [`BUS_W-1:0]       result_bus_oe_n_o,
  // converter side
  input  wire logic                    busy_i,
  input  wire logic                    conv_wr_i,
  input  wire logic [`CHAN_W-1:0]      conv_ch_i,
  input  wire adc_port_pkg::result_t   conv_data_i,
  // status
  output logic                         internal_ref_en_o,
  output adc_port_pkg::port_mode_e     mode_o
);

  import adc_port_pkg::*;

  // ----------------------------------------------------------------
  // pin filtering
  // ----------------------------------------------------------------
  logic [5:0] pins_f;
  logic       cs_f;
  logic       rd_f;
  logic       isel_f;
  logic       ref_f;
  logic       bsel_f;
  logic       hbf_f;

  pin_filter #(
    .WIDTH   (6),
    .RST_VAL (`RST_PINS)
  ) u_pin_filter (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .pin_i      ({cs_n_i, rd_sclk_i, interface_select_i, ref_select_i,
                  result_bus_i[`LINE_BYTE_SEL], result_bus_i[`LINE_HBF]}),
    .level_o    (pins_f)
  );

  assign cs_f   = pins_f[5];
  assign rd_f   = pins_f[4];
  assign isel_f = pins_f[3];
  assign ref_f  = pins_f[2];
  assign bsel_f = pins_f[1];
  assign hbf_f  = pins_f[0];

  // ----------------------------------------------------------------
  // edges
  // ----------------------------------------------------------------
  logic cs_q;
  logic rd_q;
  logic busy_q;
  logic cs_fall;
  logic rd_rise;
  logic busy_fall;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cs_q   <= 1'b1;
      rd_q   <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      cs_q   <= cs_f;
      rd_q   <= rd_f;
      busy_q <= busy_i;
    end
  end

  assign cs_fall   = cs_q & ~cs_f;
  assign rd_rise   = ~rd_q & rd_f;
  assign busy_fall = busy_q & ~busy_i;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  port_mode_e next_mode;

  always_comb begin
    if (!isel_f) begin
      next_mode = MODE_WORD;
    end else if (bsel_f) begin
      next_mode = MODE_BYTE;
    end else begin
      next_mode = MODE_SERIAL;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mode_o <= MODE_WORD;
    end else begin
      mode_o <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // reference enable
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      internal_ref_en_o <= 1'b0;
    end else begin
      internal_ref_en_o <= ref_f;
    end
  end

  // ----------------------------------------------------------------
  // result storage
  // ----------------------------------------------------------------
  // staging keeps the visible set stable while a conversion runs;
  // a read that spans the busy fall sees a mixed set
  result_t stage_mem [`CHAN_NUM];
  result_t out_mem   [`CHAN_NUM];

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `CHAN_NUM; i++) begin
        stage_mem[i] <= `RST_RESULT;
      end
    end else if (conv_wr_i) begin
      stage_mem[conv_ch_i] <= conv_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `CHAN_NUM; i++) begin
        out_mem[i] <= `RST_RESULT;
      end
    end else if (busy_fall) begin
      out_mem <= stage_mem;
    end
  end

  // ----------------------------------------------------------------
  // read pointers
  // ----------------------------------------------------------------
  logic [`CHAN_W-1:0]    ch;
  logic                  phase;
  logic [`BIT_IDX_W-1:0] bit_idx;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ch      <= '0;
      phase   <= 1'b0;
      bit_idx <= `BIT_IDX_W'(`RESULT_MSB);
    end else if (busy_fall) begin
      ch      <= '0;
      phase   <= 1'b0;
      bit_idx <= `BIT_IDX_W'(`RESULT_MSB);
    end else if (mode_o == MODE_SERIAL) begin
      if (cs_fall) begin
        ch      <= '0;
        bit_idx <= `BIT_IDX_W'(`RESULT_MSB);
      end else if (!cs_f && rd_rise) begin
        if (bit_idx == '0) begin
          bit_idx <= `BIT_IDX_W'(`RESULT_MSB);
          ch      <= {1'b0, 2'(ch[1:0] + 2'h1)};
        end else begin
          bit_idx <= bit_idx - 4'h1;
        end
      end
    end else if (!cs_f && rd_rise) begin
      if (mode_o == MODE_BYTE) begin
        phase <= ~phase;
        if (phase) begin
          ch <= ch + 3'h1;
        end
      end else begin
        ch <= ch + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus drive
  // ----------------------------------------------------------------
  result_t           word;
  logic [7:0]        upper_byte;
  logic [7:0]        lower_byte;
  logic              upper_now;
  logic              ser_a;
  logic              ser_b;
  logic              par_read;
  logic [`BUS_W-1:0] next_bus;
  logic [`BUS_W-1:0] next_oe_n;

  assign word       = out_mem[ch];
  assign upper_byte = {{2{word[`RESULT_MSB]}}, word[`RESULT_MSB:8]};
  assign lower_byte = word[7:0];
  assign upper_now  = (phase == 1'b0) ? hbf_f : ~hbf_f;
  assign ser_a      = cs_fall ? out_mem[0][`RESULT_MSB] : out_mem[{1'b0, ch[1:0]}][bit_idx];
  assign ser_b      = cs_fall ? out_mem[4][`RESULT_MSB] : out_mem[{1'b1, ch[1:0]}][bit_idx];
  assign par_read   = ~cs_f & ~rd_f;

  always_comb begin
    next_bus  = `RST_BUS;
    next_oe_n = `RST_OE_N;
    case (mode_o)
      MODE_WORD: begin
        if (par_read) begin
          next_oe_n = 16'h0000;
          next_bus  = {{2{word[`RESULT_MSB]}}, word};
        end
      end
      MODE_BYTE: begin
        if (par_read) begin
          next_oe_n[7:0] = 8'h00;
          next_bus[7:0]  = upper_now ? upper_byte : lower_byte;
        end
      end
      MODE_SERIAL: begin
        if (!cs_f) begin
          next_oe_n[`LINE_SER_A] = 1'b0;
          next_oe_n[`LINE_SER_B] = 1'b0;
          next_bus[`LINE_SER_A]  = ser_a;
          next_bus[`LINE_SER_B]  = ser_b;
        end
      end
      default: begin
        next_bus  = `RST_BUS;
        next_oe_n = `RST_OE_N;
      end
    endcase
  end

  // lines 14 and 15 double as straps outside word mode, so they stay released there
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      result_bus_o      <= `RST_BUS;
      result_bus_oe_n_o <= `RST_OE_N;
    end else begin
      result_bus_o      <= next_bus;
      result_bus_oe_n_o <= next_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  result_t word_d;

  always_ff @(posedge core_clk_i) begin
    word_d <= word;
  end

  sequence seq_word_read;
    mode_o == MODE_WORD && par_read;
  endsequence

  sequence seq_serial_start;
    mode_o == MODE_SERIAL && cs_fall;
  endsequence

  sequence seq_msb_ready;
    (bit_idx == 4'hd && ch == 3'h0) ##1 ($past(cs_f) || result_bus_oe_n_o[8:7] == 2'b00);
  endsequence

  AST_LOW_LINES: assert property (
    seq_word_read |=> result_bus_oe_n_o[6:0] == 7'h00 && result_bus_o[6:0] == word_d[6:0]
  ) else $error("low lines wrong in word read");

  AST_MID_LINES: assert property (
    seq_word_read |=> result_bus_o[8:7] == word_d[8:7] && result_bus_oe_n_o[8:7] == 2'b00
  ) else $error("lines 7 and 8 wrong in word read");

  AST_HIGH_LINES: assert property (
    seq_word_read |=> result_bus_o[13:9] == word_d[13:9] && result_bus_oe_n_o[13:9] == 5'h00
  ) else $error("lines 13 to 9 wrong in word read");

  AST_SIGN_EXT: assert property (
    seq_word_read |=> result_bus_o[15] == result_bus_o[13] && result_bus_o[14] == result_bus_o[13]
  ) else $error("sign extension wrong");

  AST_RELEASE: assert property (
    (mode_o != MODE_SERIAL && !par_read) |=> result_bus_oe_n_o == 16'hffff
  ) else $error("bus driven outside a read");

  AST_STRAP_FREE: assert property (
    (mode_o == MODE_BYTE) |=> result_bus_oe_n_o[15:8] == 8'hff
  ) else $error("upper lines driven in byte mode");

  AST_MODE: assert property (
    ##1 mode_o == (!$past(isel_f) ? MODE_WORD : ($past(bsel_f) ? MODE_BYTE : MODE_SERIAL))
  ) else $error("mode decode wrong");

  AST_SERIAL_LINES: assert property (
    (mode_o == MODE_SERIAL && !cs_f) |=> result_bus_oe_n_o == 16'hfe7f
  ) else $error("serial outputs not on lines 7 and 8");

  AST_BYTE_ORDER: assert property (
    (mode_o == MODE_BYTE && par_read && phase == 1'b0 && hbf_f)
      |=> result_bus_o[5:0] == word_d[13:8] && result_bus_oe_n_o[7:0] == 8'h00
  ) else $error("high byte not first");

  AST_BYTE_LOW: assert property (
    (mode_o == MODE_BYTE && par_read && phase == 1'b0 && !hbf_f)
      |=> result_bus_o[7:0] == word_d[7:0]
  ) else $error("low byte not first");

  AST_REF: assert property (
    $rose(ref_f) |=> internal_ref_en_o ##1 internal_ref_en_o || !ref_f
  ) else $error("reference enable not following select");

  AST_SERIAL_START: assert property (
    seq_serial_start |=> seq_msb_ready
  ) else $error("serial frame start wrong");

  AST_SERIAL_SHIFT: assert property (
    (mode_o == MODE_SERIAL && !cs_f && rd_rise && !cs_fall && !busy_fall && bit_idx != 4'h0)
      |=> bit_idx == $past(bit_idx) - 4'h1
  ) else $error("serial shift wrong");

  AST_RELOAD: assert property (
    busy_fall |=> ch == 3'h0 && phase == 1'b0 && out_mem[0] == $past(stage_mem[0])
  ) else $error("reload on busy fall wrong");

endmodule

//--- bench/host_board.sv
`timescale 1ns/100ps
`include "adc_port_defs.svh"

module host_board (
  // clock
  input  wire logic              core_clk_i,
  // mode pin and straps
  input  wire logic              interface_select_i,
  input  wire logic              byte_sel_i,
  input  wire logic              high_byte_first_i,
  // device side of the bus
  input  wire logic [`BUS_W-1:0] dev_bus_i,
  input  wire logic [`BUS_W-1:0] dev_oe_n_i,
  // resolved pin level
  output logic      [`BUS_W-1:0] bus_level_o
);
  // ----------------------------------------------------------------
  // bus resolution
  // ----------------------------------------------------------------
  logic [`BUS_W-1:0] last = '0;

  // a floating line must not look like held data, so it flips each cycle
  always @(posedge core_clk_i) begin
    last <= bus_level_o;
  end

  always_comb begin
    for (int i = 0; i < `BUS_W; i++) begin
      if (!dev_oe_n_i[i]) begin
        bus_level_o[i] = dev_bus_i[i];
      end else if (interface_select_i && i == `LINE_BYTE_SEL) begin
        bus_level_o[i] = byte_sel_i;
      end else if (interface_select_i && i == `LINE_HBF) begin
        bus_level_o[i] = high_byte_first_i;
      end else if (interface_select_i && i != `LINE_SER_A && i != `LINE_SER_B) begin
        bus_level_o[i] = 1'b0;
      end else begin
        bus_level_o[i] = ~last[i];
      end
    end
  end
endmodule

//--- bench/test_result_port.sv
`timescale 1ns/100ps

module test_result_port;
  import adc_port_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  logic        core_clk_i = 0;
  logic        rst_n_i    = 0;
  logic        cs_n       = 1;
  logic        rd_sclk    = 1;
  logic        if_sel     = 0;
  logic        ref_sel    = 0;
  logic        busy       = 0;
  logic        conv_wr    = 0;
  logic        byte_sel   = 0;
  logic        hbf        = 0;
  logic [2:0]  conv_ch    = 3'h0;
  result_t     conv_data  = '0;
  logic [15:0] bus_in;
  logic [15:0] bus_out;
  logic [15:0] oe_n;
  logic        ref_en;
  port_mode_e  mode;
  int          miscompares = 0;
  int          checked     = 0;
  int          cycles      = 0;

  result_port u_result_port (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
    .rd_sclk_i(rd_sclk), .interface_select_i(if_sel), .ref_select_i(ref_sel),
    .result_bus_i(bus_in), .result_bus_o(bus_out), .result_bus_oe_n_o(oe_n),
    .busy_i(busy), .conv_wr_i(conv_wr), .conv_ch_i(conv_ch), .conv_data_i(conv_data),
    .internal_ref_en_o(ref_en), .mode_o(mode));

  host_board u_host_board (.core_clk_i(core_clk_i), .interface_select_i(if_sel),
    .byte_sel_i(byte_sel), .high_byte_first_i(hbf), .dev_bus_i(bus_out),
    .dev_oe_n_i(oe_n), .bus_level_o(bus_in));

  initial forever #5 core_clk_i = ~core_clk_i;

  // run is about 470 cycles; ceiling leaves ample margin
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  function automatic result_t val(input logic [2:0] k);
    return {k[0] ^ k[2], ~k, 10'h25c};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic load_results();
    for (int k = 0; k < 8; k++) begin
      conv_ch   = k[2:0];
      conv_data = val(k[2:0]);
      conv_wr   = 1;
      wait_clk(1);
    end
    conv_wr = 0;
    busy    = 1;
    wait_clk(2);
    busy = 0;
    wait_clk(3);
  endtask

  task automatic par_read(output logic [15:0] d, output logic [15:0] e);
    cs_n    = 0;
    rd_sclk = 0;
    wait_clk(8);
    d       = bus_out;
    e       = oe_n;
    // read only counts when rd rises while cs is still low
    rd_sclk = 1;
    wait_clk(6);
    cs_n    = 1;
    wait_clk(8);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_ref();
    ref_sel = 1;
    wait_clk(8);
    check({15'h0, ref_en}, 16'h0001);
    ref_sel = 0;
    wait_clk(8);
    check({15'h0, ref_en}, 16'h0000);
    $display("test ref done");
  endtask

  task automatic test_word();
    logic [15:0] d;
    logic [15:0] e;
    result_t     v;
    load_results();
    check({14'h0, mode}, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      v = val(k[2:0]);
      par_read(d, e);
      check(e, 16'h0000);
      check(d, {{2{v[13]}}, v});
      check(oe_n, 16'hffff);
    end
    rd_sclk = 0;
    wait_clk(8);
    check(oe_n, 16'hffff);
    rd_sclk = 1;
    wait_clk(8);
    $display("test word done");
  endtask

  task automatic test_byte();
    logic [15:0] d;
    logic [15:0] e;
    result_t     v;
    if_sel   = 1;
    byte_sel = 1;
    hbf      = 1;
    wait_clk(8);
    check({14'h0, mode}, 16'h0001);
    load_results();
    for (int k = 0; k < 2; k++) begin
      v = val(k[2:0]);
      par_read(d, e);
      check(e, 16'hff00);
      check({8'h0, d[7:0]}, hbf ? {8'h0, {3{v[13]}}, v[12:8]} : {8'h0, v[7:0]});
      par_read(d, e);
      check({8'h0, d[7:0]}, hbf ? {8'h0, v[7:0]} : {8'h0, {3{v[13]}}, v[12:8]});
      hbf = 0;
      wait_clk(8);
    end
    $display("test byte done");
  endtask

  task automatic test_serial();
    result_t a;
    result_t b;
    a        = val(3'h0);
    b        = val(3'h4);
    byte_sel = 0;
    wait_clk(8);
    check({14'h0, mode}, 16'h0002);
    load_results();
    cs_n = 0;
    wait_clk(8);
    check({14'h0, oe_n[8:7]}, 16'h0000);
    for (int i = 13; i >= 0; i--) begin
      check({14'h0, bus_out[8], bus_out[7]}, {14'h0, b[i], a[i]});
      rd_sclk = 0;
      wait_clk(6);
      rd_sclk = 1;
      wait_clk(8);
    end
    a = val(3'h1);
    b = val(3'h5);
    check({14'h0, bus_out[8], bus_out[7]}, {14'h0, b[13], a[13]});
    cs_n = 1;
    wait_clk(8);
    check({14'h0, oe_n[8:7]}, 16'h0003);
    $display("test serial done");
  endtask

  // ----------------------------------------------------------------
  // closing and main sequence
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks made %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    wait_clk(20);
    rst_n_i = 1;
    wait_clk(2);
    check(oe_n, 16'hffff);
    check({14'h0, mode}, 16'h0000);
    test_ref();
    test_word();
    test_byte();
    test_serial();
    print_verdict();
  end
endmodule
